// ===== fei_cpu.sv
`timescale 1ns/1ns
`include "fei_defines.svh"
// processor-side error reporting for compatibility mode
module fei_cpu
    import fei_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    fei_link_if.cpu   link,
    input  wire logic native_error_select,
    input  wire logic exc_unmasked,    // pulse: unmasked exception detected
    input  wire logic exc_deferred,    // with exc_unmasked: deferred class
    input  wire logic exc_clear,       // pulse: software clears exception
    input  wire logic insn_start,      // pulse: fp instruction begins
    input  wire logic insn_nowait,     // with insn_start: no-wait class
    input  wire logic window_open,     // level: interrupt sampling window
    output logic      insn_blocked,
    output logic      take_irq,
    output logic      native_exc
);
    fei_state_type st_r, st_nxt;
    logic [`FEI_PULSE_W-1:0] cnt_r;
    logic [2:0] ign_sync_r;
    logic [2:0] int_sync_r;
    logic       ign_r;
    logic       int_r;
    logic       late_r;
    logic       blk_r;
    logic       tak_r;
    logic       nat_r;

    // pin inputs cross into mclk through three stages
    always_ff @(posedge mclk) begin
        if (rst) begin
            ign_sync_r <= 3'h0;
            int_sync_r <= 3'h0;
            ign_r      <= 1'b0;
            int_r      <= 1'b0;
        end else begin
            ign_sync_r <= {ign_sync_r[1:0], ~link.ignore_fp_error_n};
            int_sync_r <= {int_sync_r[1:0], link.cpu_interrupt_in};
            if (ign_sync_r[2] == ign_sync_r[1])
                ign_r <= ign_sync_r[2];
            if (int_sync_r[2] == int_sync_r[1])
                int_r <= int_sync_r[2];
        end
    end

    wire compat   = ~native_error_select;
    wire report   = compat & ~ign_r;
    wire pend_any = (st_r != FEI_IDLE);
    wire pulse_dn = (cnt_r == `FEI_PULSE_W'(1));

    // error engine; clear has priority since software owns the state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            FEI_IDLE: begin
                if (exc_unmasked && exc_deferred)
                    st_nxt = FEI_PENDING;
                else if (exc_unmasked)
                    st_nxt = report ? FEI_ASSERT : FEI_PENDING;
            end
            FEI_PENDING: begin
                if (report && insn_start && insn_nowait)
                    st_nxt = FEI_PULSE;
                else if (report && insn_start)
                    st_nxt = FEI_ASSERT;
            end
            FEI_ASSERT: begin
                // frozen until software clears; ignore only stops new
                // reports, dropping here would let the glue re-arm forever
                st_nxt = FEI_ASSERT;
            end
            FEI_PULSE: begin
                if (pulse_dn)
                    st_nxt = FEI_PENDING;
            end
            default: st_nxt = FEI_IDLE;
        endcase
        if (exc_clear)
            st_nxt = FEI_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            st_r <= FEI_IDLE;
        else
            st_r <= st_nxt;
    end

    // no-wait pulse length
    always_ff @(posedge mclk) begin
        if (rst)
            cnt_r <= '0;
        else if (st_nxt == FEI_PULSE && st_r != FEI_PULSE)
            cnt_r <= `FEI_NOWAIT_PULSE_CYC;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - `FEI_PULSE_W'(1);
    end

    // interrupt taken inside the window, else held to next boundary
    logic svc_r;
    // one take per request level, so take_irq stays a single pulse
    wire int_new   = int_r & ~svc_r;
    wire take_now  = int_new & window_open;
    wire take_late = (late_r | ~window_open) & int_new & insn_start;

    always_ff @(posedge mclk) begin
        if (rst) begin
            late_r <= 1'b0;
            svc_r  <= 1'b0;
            tak_r  <= 1'b0;
            blk_r  <= 1'b0;
            nat_r  <= 1'b0;
        end else begin
            tak_r  <= take_now | take_late;
            svc_r  <= int_r & (svc_r | take_now | take_late);
            if (take_now | take_late | ~int_new)
                late_r <= 1'b0;
            else if (~window_open)
                late_r <= 1'b1;
            // waiting instructions freeze on a pending error unless ignored
            blk_r  <= pend_any & compat & ~ign_r & ~insn_nowait;
            nat_r  <= native_error_select & exc_unmasked;
        end
    end

    // error output low only while asserting or pulsing
    always_ff @(posedge mclk) begin
        if (rst)
            link.fp_error_out_n <= 1'b1;
        else
            link.fp_error_out_n <= ~((st_nxt == FEI_ASSERT) ||
                                     (st_nxt == FEI_PULSE));
    end

    assign insn_blocked = blk_r;
    assign take_irq     = tak_r;
    assign native_exc   = nat_r;
endmodule

// ===== fei_defines.svh
`ifndef FEI_DEFINES_SVH
`define FEI_DEFINES_SVH

// i/o port whose access clears the request and arms ignore-error
`define FEI_CLEAR_PORT        16'h00f0
`define FEI_PORT_W            16
// error pulse width (cycles) a no-wait instruction produces
`define FEI_NOWAIT_PULSE_CYC  4'h3
`define FEI_PULSE_W           4
// number of synchroniser stages on each crossing input
`define FEI_SYNC_STAGES       3

`endif

// ===== fei_pkg.sv
package fei_pkg;
    // processor-side error engine states, one-hot
    typedef enum logic [3:0] {
        FEI_IDLE    = 4'b0001,  // no unmasked exception pending
        FEI_PENDING = 4'b0010,  // exception recorded, not yet reported
        FEI_ASSERT  = 4'b0100,  // error output driven, frozen
        FEI_PULSE   = 4'b1000   // brief no-wait pulse
    } fei_state_type;
endpackage

// ===== fei_link_if.sv
`timescale 1ns/1ns
// wires between the processor error logic and the external glue
interface fei_link_if;
    logic fp_error_out_n;       // error output, active low
    logic ignore_fp_error_n;    // ignore-error input, active low
    logic cpu_interrupt_in;     // interrupt request to the processor

    modport cpu (
        output fp_error_out_n,
        input  ignore_fp_error_n,
        input  cpu_interrupt_in
    );
    modport glue (
        input  fp_error_out_n,
        output ignore_fp_error_n,
        output cpu_interrupt_in
    );
endinterface

// ===== fei_glue.sv
`timescale 1ns/1ns
`include "fei_defines.svh"
// external glue: request latch and ignore-error latch
module fei_glue
    import fei_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    fei_link_if.glue                   link,
    input  wire logic                  io_strobe,
    input  wire logic [`FEI_PORT_W-1:0] io_addr,
    input  wire logic                  pic_enable,
    output logic                       fp_error_irq_req,
    output logic                       pic_fp_error_irq_req_line
);
    logic [2:0] err_sync_r;
    logic [2:0] stb_sync_r;
    logic       err_seen_r;
    logic       stb_seen_r;
    logic       stb_prev_r;
    logic       req_r;
    logic       ign_r;
    logic [`FEI_PORT_W-1:0] addr_r;

    // three-stage synchronisers; a change counts when stages 2 and 3 agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            err_sync_r <= 3'h0;
            stb_sync_r <= 3'h0;
            err_seen_r <= 1'b0;
            stb_seen_r <= 1'b0;
        end else begin
            err_sync_r <= {err_sync_r[1:0], ~link.fp_error_out_n};
            stb_sync_r <= {stb_sync_r[1:0], io_strobe};
            if (err_sync_r[2] == err_sync_r[1])
                err_seen_r <= err_sync_r[2];
            if (stb_sync_r[2] == stb_sync_r[1])
                stb_seen_r <= stb_sync_r[2];
        end
    end

    // address is held stable by the bus while the strobe is up
    always_ff @(posedge mclk) begin
        if (rst)
            addr_r <= '0;
        else
            addr_r <= io_addr;
    end

    wire err_active = err_seen_r;
    wire stb_rise   = stb_seen_r & ~stb_prev_r;
    wire port_hit   = stb_rise && (addr_r == `FEI_CLEAR_PORT);
    wire err_rise;
    logic err_prev_r;
    assign err_rise = err_active & ~err_prev_r;

    // request latch: set on error edge wins over port clear, so a pulse
    // landing with the access is not lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            req_r      <= 1'b0;
            stb_prev_r <= 1'b0;
            err_prev_r <= 1'b0;
        end else begin
            stb_prev_r <= stb_seen_r;
            err_prev_r <= err_active;
            if (err_rise)
                req_r <= 1'b1;
            else if (port_hit)
                req_r <= 1'b0;
        end
    end

    // ignore latch: cleared whenever error is inactive, so it cannot
    // outlive the handler regardless of software ordering
    always_ff @(posedge mclk) begin
        if (rst)
            ign_r <= 1'b0;
        else if (!err_active)
            ign_r <= 1'b0;
        else if (port_hit)
            ign_r <= 1'b1;
    end

    assign link.ignore_fp_error_n = ~ign_r;
    assign fp_error_irq_req       = req_r;
    // controller mask gates the line; processor sees the line as request
    assign pic_fp_error_irq_req_line        = req_r & pic_enable;
    assign link.cpu_interrupt_in  = pic_fp_error_irq_req_line;
endmodule

// ===== fei_link_checker.sv
`timescale 1ns/1ns
// watches the error link between processor logic and glue
module fei_link_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic fp_error_out_n,
    input wire logic ignore_fp_error_n,
    input wire logic cpu_interrupt_in
);
    logic [3:0] since_err_r;
    logic [3:0] since_err_nxt;

    // cycles since error was last low; saturates so it never wraps
    assign since_err_nxt = !fp_error_out_n ? 4'h0 :
                           (since_err_r == 4'hf) ? since_err_r :
                           since_err_r + 4'h1;
    always_ff @(posedge mclk) begin
        since_err_r <= rst ? 4'hf : since_err_nxt;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_release_idle: assert property ($fell(rst) |->
        ignore_fp_error_n && fp_error_out_n && !cpu_interrupt_in)
        else $error("link not idle after reset");
    a_err_to_irq: assert property ($fell(fp_error_out_n) |->
        ##[3:7] cpu_interrupt_in) else $error("error not latched");
    a_irq_cause: assert property ($rose(cpu_interrupt_in) |->
        since_err_r <= 4'h8) else $error("irq without error");
    a_ign_off_idle: assert property (fp_error_out_n [*8] |->
        ignore_fp_error_n) else $error("ignore on while error idle");
    a_ign_drop: assert property ($rose(fp_error_out_n) |->
        ##[1:8] ignore_fp_error_n) else $error("ignore left on");
    a_ign_clr_irq: assert property ($fell(ignore_fp_error_n) |->
        ##[0:2] !cpu_interrupt_in) else $error("irq not cleared");
    a_ign_holds: assert property ($fell(ignore_fp_error_n) &&
        !fp_error_out_n |=> !ignore_fp_error_n)
        else $error("ignore glitched");
    a_ign_needs_err: assert property ($fell(ignore_fp_error_n) |->
        since_err_r <= 4'h5) else $error("ignore without error");
endmodule

// ===== tb.sv
`timescale 1ns/1ns
// drives both ends joined by the link and compares with expectations
module tb;
    logic        mclk;
    logic        rst;
    logic        io_strobe;
    logic [15:0] io_addr;
    logic        pic_enable;
    logic        native_sel;
    logic        window_open;
    logic [4:0]  act_v;  // unmasked, deferred, clear, start, nowait
    logic        req;
    logic        line;
    logic        blocked;
    logic        take_irq;
    logic        native_exc;
    int          err_total;
    int          checks_done;
    int          takes;
    int          nexcs;

    fei_link_if link();
    fei_glue i_fei_glue (.mclk(mclk), .rst(rst), .link(link),
        .io_strobe(io_strobe), .io_addr(io_addr), .pic_enable(pic_enable),
        .fp_error_irq_req(req), .pic_fp_error_irq_req_line(line));
    fei_cpu i_fei_cpu (.mclk(mclk), .rst(rst), .link(link),
        .native_error_select(native_sel), .exc_unmasked(act_v[4]),
        .exc_deferred(act_v[3]), .exc_clear(act_v[2]),
        .insn_start(act_v[1]), .insn_nowait(act_v[0]),
        .window_open(window_open), .insn_blocked(blocked),
        .take_irq(take_irq), .native_exc(native_exc));
    fei_link_checker i_fei_link_checker (.mclk(mclk), .rst(rst),
        .fp_error_out_n(link.fp_error_out_n),
        .ignore_fp_error_n(link.ignore_fp_error_n),
        .cpu_interrupt_in(link.cpu_interrupt_in));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // one-cycle pulses are counted so the sequence can check them later
    always @(posedge mclk) begin
        if (take_irq === 1'b1) takes++;
        if (native_exc === 1'b1) nexcs++;
    end

    task wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task act(input logic [4:0] v);
        @(negedge mclk) act_v = v;
        @(negedge mclk) act_v = 5'h00;
    endtask
    // strobe held two cycles, address kept until the next access
    task port(input logic [15:0] a);
        @(negedge mclk) io_addr = a;
        io_strobe = 1'b1;
        wt(2);
        io_strobe = 1'b0;
        wt(8);
    endtask
    task chk(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", n, e, g);
        end
    endtask
    task chkn(input string n, input int e, input int g);
        checks_done++;
        if (g != e) begin
            err_total++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task wait_irq;
        int i;
        for (i = 0; i < 20 && link.cpu_interrupt_in !== 1'b1; i++) wt(1);
        if (i == 20) begin
            err_total++;
            $display("FAIL irq line expected 1 seen 0");
            wrap_up;
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {rst, io_strobe, io_addr, pic_enable} = {1'b1, 1'b0, 16'h0000, 1'b1};
        {native_sel, window_open, act_v} = 7'h00;
        err_total = 0;
        checks_done = 0;
        takes = 0;
        nexcs = 0;
        wt(6);
        rst = 1'b0;
        wt(4);
        chk("error", 1'b1, link.fp_error_out_n);
        chk("ignore", 1'b1, link.ignore_fp_error_n);
        act(5'h10);
        chk("error", 1'b0, link.fp_error_out_n);
        wait_irq;
        chk("line", 1'b1, line);
        port(16'h00f1);
        chk("request", 1'b1, req);
        port(16'h00f0);
        chk("request", 1'b0, req);
        chk("ignore", 1'b0, link.ignore_fp_error_n);
        act(5'h02);
        chk("blocked", 1'b0, blocked);
        act(5'h04);
        wt(8);
        chk("error", 1'b1, link.fp_error_out_n);
        chk("ignore", 1'b1, link.ignore_fp_error_n);
        act(5'h10);
        wait_irq;
        act(5'h04);
        wt(8);
        port(16'h00f0);
        chk("ignore", 1'b1, link.ignore_fp_error_n);
        act(5'h18);
        wt(3);
        chk("error", 1'b1, link.fp_error_out_n);
        window_open = 1'b1;
        act(5'h02);
        chk("error", 1'b0, link.fp_error_out_n);
        chk("blocked", 1'b1, blocked);
        wait_irq;
        wt(8);
        chkn("takes", 1, takes);
        window_open = 1'b0;
        port(16'h00f0);
        act(5'h04);
        wt(8);
        act(5'h18);
        act(5'h03);
        chk("error", 1'b0, link.fp_error_out_n);
        wt(4);
        chk("error", 1'b1, link.fp_error_out_n);
        wait_irq;
        wt(8);
        chkn("takes", 1, takes);
        act(5'h02);
        wt(3);
        chkn("takes", 2, takes);
        port(16'h00f0);
        act(5'h04);
        wt(8);
        act(5'h03);
        chk("error", 1'b1, link.fp_error_out_n);
        wt(8);
        chk("request", 1'b0, req);
        native_sel = 1'b1;
        act(5'h10);
        wt(2);
        chk("error", 1'b1, link.fp_error_out_n);
        chkn("native", 1, nexcs);
        wrap_up;
    end
endmodule
